// ===== ptb_defs.svh
// Offsets, bit positions, reset values and sizes of the trailer builder.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PTB_DEFS_SVH
`define PTB_DEFS_SVH

// ----------------------------------------
// Trailer word layout
// ----------------------------------------
`define PTB_EN_VALID 30
`define PTB_EN_LOCK 29
`define PTB_EN_INV 26
`define PTB_EN_OVR 25
`define PTB_EN_LOSS 24
`define PTB_IND_VALID 18
`define PTB_IND_LOCK 17
`define PTB_IND_INV 14
`define PTB_IND_OVR 13
`define PTB_IND_LOSS 12
`define PTB_CTX_FLAG 7
`define PTB_CTX_CNT_HI 6
`define PTB_USED_MASK 32'h67067000

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PTB_ADDR_W 8
`define PTB_OFS_CTRL 8'h00
`define PTB_OFS_STATUS 8'h04
`define PTB_OFS_IRQ_STAT 8'h08
`define PTB_OFS_IRQ_CLR 8'h0C
`define PTB_OFS_IRQ_EN 8'h10
`define PTB_OFS_LAST 8'h14
`define PTB_OFS_COUNT 8'h18

// ----------------------------------------
// Control fields
// ----------------------------------------
`define PTB_CTRL_MASK_HI 4
`define PTB_CTRL_MASK_W 5
`define PTB_CTRL_HDR 5
`define PTB_CTRL_STREAM 6
`define PTB_CTRL_CONN 7
`define PTB_CTRL_MODE_LO 8
`define PTB_CTRL_MODE_HI 9
`define PTB_CTRL_INV 10
`define PTB_CTRL_RST 32'h0000001F
`define PTB_MODE_DIRECT 2'h0

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define PTB_IRQ_W 4
`define PTB_IRQ_UNLOCK 0
`define PTB_IRQ_OVR 1
`define PTB_IRQ_LOSS 2
`define PTB_IRQ_SENT 3
`define PTB_IRQ_RST 4'h0

`endif

// ===== ptb_pkg.sv
// Types shared by the trailer builder modules.
// Assumes ptb_defs.svh is on the include path.
`include "ptb_defs.svh"

package ptb_pkg;

	typedef enum logic {ST_PAYLOAD, ST_TRAILER} ptb_state_t;

	typedef struct packed {
		ptb_state_t state;
		logic [31:0] ctrl;
		logic [`PTB_IRQ_W-1:0] irq_stat;
		logic [`PTB_IRQ_W-1:0] irq_en;
		logic [31:0] rdata;
		logic out_valid;
		logic [31:0] out_data;
		logic out_last;
		logic ovr_seen;
		logic loss_pending;
		logic lock_prev;
		logic spec_gpio;
		logic [31:0] last_trailer;
		logic [31:0] pkt_count;
	} ptb_regs_t;

endpackage

// ===== ptb_sync2.sv
// Two-flop synchroniser for a group of level inputs.
// Assumes inputs come from outside the CORE_CLK domain.
`timescale 1ns/1ps
`include "ptb_defs.svh"

module ptb_sync2 #(
	parameter int WIDTH = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} ptb_sync_t;

	ptb_sync_t sync_reg;
	ptb_sync_t sync_next;

	// First stage feeds only the second stage
	always_comb begin
		sync_next.s1 = async_in;
		sync_next.s2 = sync_reg.s1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg.s2;

endmodule

// ===== ptb_trailer.sv
// Trailer builder: passes packet payload words and closes each packet
// with one indicator trailer word; register port and interrupt.
// Assumes one CORE_CLK domain; PLL lock and filter settle arrive async.
//
// Behaviour
// R01 - Append one trailer after every packet payload
// R02 - Each indicator has enable at matching position
// R03 - Indicator meaningful only while its enable set
// R04 - Unused enable and indicator bits zero
// R05 - Context count valid flag bit 7 zero
// R06 - Context packet count field all zeros
// R07 - Valid data bit 18, enable 30
// R08 - Clear valid on unlock or unsettled filter; filter ignored outside high dynamic range mode
// R09 - Reference lock bit 17, enable 29
// R10 - Spectral inversion bit 14, enable 26
// R11 - Inversion on GPIO in connector superhet mode
// R12 - Receiver swaps IQ or reverses bins
// R13 - Over-range bit 13, enable 25, per packet
// R14 - Sample loss bit 12, enable 24
// R15 - Loss only on stream-mode buffer overflow
// R16 - Hold loss pending until trailer reports it
`timescale 1ns/1ps
`include "ptb_defs.svh"

module ptb_trailer #(
	parameter int CNT_W = 32
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic [`PTB_ADDR_W-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	output logic IRQ,
	input wire logic PLL_LOCK,
	input wire logic NB_FILTER_SETTLED,
	input wire logic BUF_DROP,
	input wire logic IN_VALID,
	input wire logic [31:0] IN_DATA,
	input wire logic IN_LAST,
	input wire logic IN_OVR,
	output logic IN_READY,
	output logic OUT_VALID,
	output logic [31:0] OUT_DATA,
	output logic OUT_LAST,
	input wire logic OUT_READY,
	output logic SPEC_INV_GPIO
);

	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	generate
		if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
			$error("CNT_W must lie in 1..32");
		end
	endgenerate

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] pins_sync;

	ptb_sync2 #(
		.WIDTH(2)
	) u_sync (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.async_in({NB_FILTER_SETTLED, PLL_LOCK}),
		.sync_out(pins_sync)
	);

	logic pll_locked;
	logic filt_settled;
	assign pll_locked = pins_sync[0];
	assign filt_settled = pins_sync[1];

	// ----------------------------------------
	// Trailer word
	// ----------------------------------------
	// Indicators are forced low when disabled so disabled bits read as unused
	function automatic logic [31:0] build_trailer(
		input logic [`PTB_CTRL_MASK_W-1:0] en,
		input logic valid,
		input logic lock,
		input logic inv,
		input logic ovr,
		input logic loss
	);
		logic [31:0] w;
		w = 32'h00000000; // see R04 see R05 see R06
		w[`PTB_EN_VALID] = en[0]; // see R02 see R07
		w[`PTB_EN_LOCK] = en[1]; // see R09
		w[`PTB_EN_INV] = en[2]; // see R10
		w[`PTB_EN_OVR] = en[3]; // see R13
		w[`PTB_EN_LOSS] = en[4]; // see R14
		w[`PTB_IND_VALID] = en[0] & valid; // see R03 see R07
		w[`PTB_IND_LOCK] = en[1] & lock; // see R09
		w[`PTB_IND_INV] = en[2] & inv; // see R10
		w[`PTB_IND_OVR] = en[3] & ovr; // see R13
		w[`PTB_IND_LOSS] = en[4] & loss; // see R14
		return w;
	endfunction

	ptb_pkg::ptb_regs_t r_reg;
	ptb_pkg::ptb_regs_t r_next;

	logic load_ok;
	logic accept;
	logic emit;
	logic data_valid;
	logic stream_mode;
	logic drop_event;
	logic [31:0] trailer;
	logic [1:0] in_mode;
	logic [`PTB_IRQ_W-1:0] irq_events;

	assign load_ok = !r_reg.out_valid || OUT_READY;
	assign IN_READY = (r_reg.state == ptb_pkg::ST_PAYLOAD) && load_ok; // see R01
	assign accept = IN_VALID && IN_READY;
	assign emit = (r_reg.state == ptb_pkg::ST_TRAILER) && load_ok;
	assign stream_mode = r_reg.ctrl[`PTB_CTRL_STREAM];
	assign drop_event = BUF_DROP && stream_mode; // see R15
	assign in_mode = r_reg.ctrl[`PTB_CTRL_MODE_HI:`PTB_CTRL_MODE_LO];
	// Unsettled filter matters only in high dynamic range mode
	assign data_valid = pll_locked && !(r_reg.ctrl[`PTB_CTRL_HDR] && !filt_settled); // see R08
	assign trailer = build_trailer(r_reg.ctrl[`PTB_CTRL_MASK_HI:0], data_valid, pll_locked,
		r_reg.ctrl[`PTB_CTRL_INV], r_reg.ovr_seen, r_reg.loss_pending);

	always_comb begin
		irq_events = '0;
		irq_events[`PTB_IRQ_UNLOCK] = r_reg.lock_prev && !pll_locked;
		irq_events[`PTB_IRQ_OVR] = emit && trailer[`PTB_IND_OVR];
		irq_events[`PTB_IRQ_LOSS] = drop_event;
		irq_events[`PTB_IRQ_SENT] = emit;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.rdata = 32'h00000000;
		r_next.lock_prev = pll_locked;
		if (OUT_READY) begin
			r_next.out_valid = 1'b0;
		end
		case (r_reg.state)
			ptb_pkg::ST_PAYLOAD: begin
				if (accept) begin
					r_next.out_valid = 1'b1;
					r_next.out_data = IN_DATA;
					r_next.out_last = 1'b0;
					r_next.ovr_seen = r_reg.ovr_seen | IN_OVR; // see R13
					if (IN_LAST) begin
						r_next.state = ptb_pkg::ST_TRAILER; // see R01
					end
				end
			end
			ptb_pkg::ST_TRAILER: begin
				if (emit) begin
					r_next.out_valid = 1'b1;
					r_next.out_data = trailer;
					r_next.out_last = 1'b1;
					r_next.ovr_seen = 1'b0;
					r_next.last_trailer = trailer;
					r_next.pkt_count = r_reg.pkt_count + 32'h00000001;
					r_next.state = ptb_pkg::ST_PAYLOAD;
					if (trailer[`PTB_IND_LOSS]) begin
						r_next.loss_pending = 1'b0; // see R16
					end
				end
			end
			default: begin
				r_next.state = ptb_pkg::ST_PAYLOAD;
			end
		endcase
		// A drop in the emit cycle stays pending for the next packet
		if (drop_event) begin
			r_next.loss_pending = 1'b1; // see R15 see R16
		end
		r_next.spec_gpio = r_reg.ctrl[`PTB_CTRL_CONN] && (in_mode != `PTB_MODE_DIRECT)
			&& r_reg.ctrl[`PTB_CTRL_INV]; // see R11
		// Register port
		if (WR) begin
			case (ADDR)
				`PTB_OFS_CTRL: r_next.ctrl = WDATA;
				`PTB_OFS_IRQ_EN: r_next.irq_en = WDATA[`PTB_IRQ_W-1:0];
				default: r_next.ctrl = r_next.ctrl;
			endcase
		end
		if (RD) begin
			case (ADDR)
				`PTB_OFS_CTRL: r_next.rdata = r_reg.ctrl;
				`PTB_OFS_STATUS: r_next.rdata = {27'h0, r_reg.state == ptb_pkg::ST_TRAILER,
					r_reg.ovr_seen, r_reg.loss_pending, filt_settled, pll_locked};
				`PTB_OFS_IRQ_STAT: r_next.rdata = {28'h0, r_reg.irq_stat};
				`PTB_OFS_IRQ_EN: r_next.rdata = {28'h0, r_reg.irq_en};
				`PTB_OFS_LAST: r_next.rdata = r_reg.last_trailer;
				`PTB_OFS_COUNT: r_next.rdata = r_reg.pkt_count;
				default: r_next.rdata = 32'h00000000;
			endcase
		end
		// Set wins over a clear in the same cycle
		r_next.irq_stat = r_reg.irq_stat | irq_events;
		if (WR && ADDR == `PTB_OFS_IRQ_CLR) begin
			r_next.irq_stat = (r_reg.irq_stat & ~WDATA[`PTB_IRQ_W-1:0]) | irq_events;
		end
		if (CNT_W < 32) begin
			r_next.pkt_count = r_next.pkt_count & ((32'h00000001 << CNT_W) - 32'h00000001);
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			r_reg <= '0;
			r_reg.ctrl <= `PTB_CTRL_RST;
			r_reg.irq_stat <= `PTB_IRQ_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign RDATA = r_reg.rdata;
	assign IRQ = |(r_reg.irq_stat & r_reg.irq_en);
	assign OUT_VALID = r_reg.out_valid;
	assign OUT_DATA = r_reg.out_data;
	assign OUT_LAST = r_reg.out_last;
	assign SPEC_INV_GPIO = r_reg.spec_gpio;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	unused_zero_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R04
		(OUT_VALID && OUT_LAST) |-> ((OUT_DATA & ~`PTB_USED_MASK) == 32'h00000000))
		else $error("trailer has unused bits set");

	ctx_flag_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R05
		(OUT_VALID && OUT_LAST) |-> !OUT_DATA[`PTB_CTX_FLAG])
		else $error("context count flag set");

	ctx_count_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R06
		(OUT_VALID && OUT_LAST) |-> (OUT_DATA[`PTB_CTX_CNT_HI:0] == 7'h00))
		else $error("context count not zero");

	enable_pair_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R03
		(OUT_VALID && OUT_LAST) |-> ((OUT_DATA[18:12] & ~OUT_DATA[30:24]) == 7'h00))
		else $error("indicator set without its enable");

	enable_mask_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R02
		(emit && !(WR && ADDR == `PTB_OFS_CTRL)) |=> ({OUT_DATA[24], OUT_DATA[25],
		OUT_DATA[26], OUT_DATA[29], OUT_DATA[30]} == r_reg.ctrl[`PTB_CTRL_MASK_HI:0]))
		else $error("trailer enables differ from mask");

	trailer_follows_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R01
		(accept && IN_LAST) |=> (!IN_READY && !OUT_LAST))
		else $error("payload taken before trailer");

	valid_lock_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R08
		(OUT_VALID && OUT_LAST && OUT_DATA[30] && OUT_DATA[29] && OUT_DATA[18])
		|-> OUT_DATA[17])
		else $error("valid data without reference lock");

	loss_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R16
		(emit && trailer[`PTB_IND_LOSS] && !drop_event) |=> !r_reg.loss_pending)
		else $error("loss pending not cleared after report");

	stream_only_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R15
		$rose(r_reg.loss_pending) |-> $past(BUF_DROP && stream_mode))
		else $error("loss raised outside stream overflow");

	over_range_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R13
		(accept && IN_OVR) |=> r_reg.ovr_seen)
		else $error("over-range sample not recorded");

	gpio_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R11
		(!r_reg.ctrl[`PTB_CTRL_CONN] ##1 !r_reg.ctrl[`PTB_CTRL_CONN]) |-> !SPEC_INV_GPIO)
		else $error("GPIO inversion outside connector mode");

	gpio_on_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R11
		(r_reg.ctrl[`PTB_CTRL_CONN] && in_mode != `PTB_MODE_DIRECT && r_reg.ctrl[`PTB_CTRL_INV])
		|=> SPEC_INV_GPIO)
		else $error("GPIO inversion missing in connector mode");

	valid_unlock_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R08
		(emit && !pll_locked) |=> !OUT_DATA[`PTB_IND_VALID])
		else $error("valid data set while unlocked");

	valid_settle_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R08
		(emit && r_reg.ctrl[`PTB_CTRL_HDR] && !filt_settled)
		|=> !OUT_DATA[`PTB_IND_VALID])
		else $error("valid data set before filter settled");

	lock_bit_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R09
		(emit && r_reg.ctrl[1]) |=> (OUT_DATA[`PTB_IND_LOCK] == $past(pll_locked)))
		else $error("lock indicator differs from lock pin");

	inv_bit_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R10
		(emit && r_reg.ctrl[2]) |=> (OUT_DATA[`PTB_IND_INV] == $past(r_reg.ctrl[`PTB_CTRL_INV])))
		else $error("inversion indicator differs from state");

	ovr_bit_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R13
		(emit && r_reg.ctrl[3]) |=> (OUT_DATA[`PTB_IND_OVR] == $past(r_reg.ovr_seen)))
		else $error("over-range indicator differs from packet");

	ovr_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R13
		emit |=> !r_reg.ovr_seen)
		else $error("over-range carried into next packet");

	loss_bit_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R14
		(emit && r_reg.ctrl[4]) |=> (OUT_DATA[`PTB_IND_LOSS] == $past(r_reg.loss_pending)))
		else $error("loss indicator differs from pending loss");

	loss_set_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R15
		drop_event |=> r_reg.loss_pending)
		else $error("stream drop not recorded");

	loss_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R16
		(r_reg.loss_pending && !emit) |=> r_reg.loss_pending)
		else $error("pending loss lost before report");

	out_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R01
		(OUT_VALID && !OUT_READY) |=> (OUT_VALID && $stable(OUT_DATA) && $stable(OUT_LAST)))
		else $error("output word changed while stalled");

	ready_trailer_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R01
		(r_reg.state == ptb_pkg::ST_TRAILER) |-> !IN_READY)
		else $error("payload ready while trailer pending");

	one_trailer_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see R01
		(OUT_VALID && OUT_READY && OUT_LAST) |=> !(OUT_VALID && OUT_LAST))
		else $error("two trailers in a row");

	rdata_idle_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		!RD |=> (RDATA == 32'h00000000))
		else $error("read data without read strobe");

	irq_sticky_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(r_reg.irq_stat[`PTB_IRQ_LOSS] && !(WR && ADDR == `PTB_OFS_IRQ_CLR))
		|=> r_reg.irq_stat[`PTB_IRQ_LOSS])
		else $error("status bit dropped without clear");

	irq_set_wins_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(drop_event && WR && ADDR == `PTB_OFS_IRQ_CLR) |=> r_reg.irq_stat[`PTB_IRQ_LOSS])
		else $error("clear beat a new event");

endmodule

// ===== ptb_host_model.sv
// Host side model: takes stream words from the builder and keeps the last trailer.
// Assumes one clock; slow makes it stall every other cycle.
`timescale 1ns/1ps

module ptb_host_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic in_valid,
	input wire logic [31:0] in_data,
	input wire logic in_last,
	output logic ready,
	output logic [31:0] trailer,
	output logic [15:0] n_trl,
	output logic [15:0] n_words,
	output logic inv_seen
);
	logic ph_reg;

	// ----------------------------------------
	// Acceptance
	// ----------------------------------------
	// Stalls expose any word that does not hold while ready is low
	assign ready = !slow || ph_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_reg <= 1'b0;
			trailer <= 32'h00000000;
			n_trl <= 16'h0000;
			n_words <= 16'h0000;
			inv_seen <= 1'b0;
		end else begin
			ph_reg <= ~ph_reg;
			if (in_valid && ready) begin
				n_words <= n_words + 16'h0001;
				if (in_last) begin
					trailer <= in_data;
					n_trl <= n_trl + 16'h0001;
					// Inversion counts only with its enable; it is only flagged in inv_seen, with no swap or bin reversal
					inv_seen <= in_data[26] && in_data[14];
				end
			end
		end
	end
endmodule

// ===== ptb_trailer_bench.sv
// Self-checking bench for the trailer builder: table of packets, then hand tests.
// Assumes ptb_defs.svh on the include path and ptb_host_model beside it.
`timescale 1ns/1ps
`include "ptb_defs.svh"

module ptb_trailer_bench;
	typedef struct packed {
		logic [31:0] ctrl;
		logic pll;
		logic setl;
		logic ovr;
		logic [31:0] trl;
	} ptb_row_t;
	ptb_row_t rows [5] = '{
		'{32'h0000001F, 1'b1, 1'b1, 1'b0, 32'h67060000},
		'{32'h0000041F, 1'b1, 1'b1, 1'b1, 32'h67066000},
		'{32'h0000003F, 1'b1, 1'b0, 1'b0, 32'h67020000},
		'{32'h0000001F, 1'b0, 1'b1, 1'b0, 32'h67000000},
		'{32'h00000400, 1'b1, 1'b1, 1'b1, 32'h00000000}};
	logic CORE_CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0, IRQ, IN_READY, OUT_VALID;
	logic [7:0] ADDR = 8'h00;
	logic [31:0] WDATA = 32'h00000000, RDATA, OUT_DATA, IN_DATA = 32'h00000000, v, trailer;
	logic PLL_LOCK = 1'b1, NB_FILTER_SETTLED = 1'b1, BUF_DROP = 1'b0, IN_VALID = 1'b0;
	logic IN_LAST = 1'b0, IN_OVR = 1'b0, OUT_LAST, OUT_READY, SPEC_INV_GPIO, slow = 1'b0, inv;
	logic [15:0] n_trl, n_words;
	int n_fail = 0, compares = 0, cyc = 0;

	always #5 CORE_CLK = ~CORE_CLK;

	ptb_trailer uut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .PLL_LOCK(PLL_LOCK),
		.NB_FILTER_SETTLED(NB_FILTER_SETTLED), .BUF_DROP(BUF_DROP), .IN_VALID(IN_VALID),
		.IN_DATA(IN_DATA), .IN_LAST(IN_LAST), .IN_OVR(IN_OVR), .IN_READY(IN_READY),
		.OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .OUT_LAST(OUT_LAST),
		.OUT_READY(OUT_READY), .SPEC_INV_GPIO(SPEC_INV_GPIO));
	ptb_host_model host (.clk(CORE_CLK), .rst_n(RST_N), .slow(slow), .in_valid(OUT_VALID),
		.in_data(OUT_DATA), .in_last(OUT_LAST), .ready(OUT_READY), .trailer(trailer),
		.n_trl(n_trl), .n_words(n_words), .inv_seen(inv));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CORE_CLK);
		WR <= 1'b0;
	endtask

	// Data stand only in the cycle after the strobe
	task rd(input logic [7:0] a);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		@(posedge CORE_CLK);
		v = RDATA;
	endtask

	// Two payload words, then wait for the trailer at the host
	task pkt(input logic ovr);
		logic [15:0] k;
		k = n_trl;
		for (int i = 0; i < 2; i++) begin
			IN_VALID <= 1'b1;
			IN_DATA <= 32'hA5000000 + i;
			IN_LAST <= (i == 1);
			IN_OVR <= ovr && (i == 1);
			do @(posedge CORE_CLK); while (IN_READY !== 1'b1);
		end
		IN_VALID <= 1'b0;
		IN_LAST <= 1'b0;
		IN_OVR <= 1'b0;
		for (int j = 0; j < 40 && n_trl == k; j++) @(posedge CORE_CLK);
		chk("trailer count", {16'h0000, k + 16'h0001}, {16'h0000, n_trl});
	endtask

	task end_of_test;
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Whole run is under two hundred cycles
	always @(posedge CORE_CLK) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			end_of_test;
		end
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge CORE_CLK);
		chk("reset rdata", 32'h00000000, RDATA);
		chk("reset outputs", 32'h00000004, {26'h0, OUT_LAST, |OUT_DATA, IRQ, IN_READY, OUT_VALID,
			SPEC_INV_GPIO});
		RST_N <= 1'b1;
		@(posedge CORE_CLK);
		rd(`PTB_OFS_CTRL);
		chk("ctrl reset", 32'h0000001F, v);
		$display("reset test done");
		for (int i = 0; i < 5; i++) begin
			slow <= i[0];
			wr(`PTB_OFS_CTRL, rows[i].ctrl);
			PLL_LOCK <= rows[i].pll;
			NB_FILTER_SETTLED <= rows[i].setl;
			repeat (4) @(posedge CORE_CLK);
			pkt(rows[i].ovr);
			chk("trailer", rows[i].trl, trailer);
			chk("host inversion", {31'h0, rows[i].ctrl[10] && rows[i].ctrl[2]}, {31'h0, inv});
			$display("row %0d done", i);
		end
		slow <= 1'b0;
		wr(`PTB_OFS_CTRL, 32'h0000001F);
		PLL_LOCK <= 1'b1;
		NB_FILTER_SETTLED <= 1'b1;
		@(posedge CORE_CLK);
		wr(`PTB_OFS_IRQ_EN, 32'h00000004);
		BUF_DROP <= 1'b1;
		@(posedge CORE_CLK);
		BUF_DROP <= 1'b0;
		pkt(1'b0);
		chk("no loss outside stream", 32'h67060000, trailer);
		wr(`PTB_OFS_CTRL, 32'h0000005F);
		BUF_DROP <= 1'b1;
		@(posedge CORE_CLK);
		BUF_DROP <= 1'b0;
		@(posedge CORE_CLK);
		chk("irq on drop", 32'h1, {31'h0, IRQ});
		rd(`PTB_OFS_IRQ_STAT);
		chk("drop status", 32'h0000000F, v);
		wr(`PTB_OFS_IRQ_CLR, 32'h00000004);
		@(posedge CORE_CLK);
		chk("irq cleared", 32'h0, {31'h0, IRQ});
		pkt(1'b0);
		chk("loss reported", 32'h67061000, trailer);
		pkt(1'b0);
		chk("loss cleared", 32'h67060000, trailer);
		$display("loss test done");
		wr(`PTB_OFS_CTRL, 32'h0000059F);
		repeat (2) @(posedge CORE_CLK);
		chk("gpio superhet", 32'h1, {31'h0, SPEC_INV_GPIO});
		wr(`PTB_OFS_CTRL, 32'h0000049F);
		repeat (2) @(posedge CORE_CLK);
		chk("gpio direct", 32'h0, {31'h0, SPEC_INV_GPIO});
		rd(8'h1C);
		chk("unmapped read", 32'h0, v);
		rd(`PTB_OFS_COUNT);
		chk("count", 32'd8, v);
		chk("words", 32'd24, {16'h0000, n_words});
		rd(`PTB_OFS_LAST);
		chk("last trailer", 32'h67060000, v);
		rd(`PTB_OFS_STATUS);
		chk("status", 32'h00000003, v);
		$display("register test done");
		RST_N <= 1'b0;
		repeat (3) @(posedge CORE_CLK);
		chk("mid reset outputs", 32'h00000004, {26'h0, OUT_LAST, |OUT_DATA, IRQ, IN_READY,
			OUT_VALID, SPEC_INV_GPIO});
		RST_N <= 1'b1;
		@(posedge CORE_CLK);
		rd(`PTB_OFS_COUNT);
		chk("count after reset", 32'h00000000, v);
		rd(`PTB_OFS_CTRL);
		chk("ctrl after reset", 32'h0000001F, v);
		$display("mid-run reset test done");
		end_of_test;
	end
endmodule
